// ===== hw/twm_regs.svh
// Register offsets, field positions, status codes and timing counts of the two-wire master.
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH
// -----------------------------------------------------------------------------
// Register byte offsets on APB
// -----------------------------------------------------------------------------
`define TWM_OFS_CTRL 8'h00
`define TWM_OFS_STATUS 8'h04
`define TWM_OFS_DATA 8'h08
`define TWM_OFS_IRQ_STAT 8'h0C
`define TWM_OFS_IRQ_MASK 8'h10
// -----------------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------------
`define TWM_CTRL_FLAG 7
`define TWM_CTRL_ACK 6
`define TWM_CTRL_STA 5
`define TWM_CTRL_STO 4
`define TWM_CTRL_WCOL 3
`define TWM_CTRL_EN 2
`define TWM_CTRL_IE 0
`define TWM_RW_BIT 0
// -----------------------------------------------------------------------------
// Status codes and reset values
// -----------------------------------------------------------------------------
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_W_ACK 8'h18
`define TWM_ST_W_NACK 8'h20
`define TWM_ST_ARB 8'h38
`define TWM_ST_R_ACK 8'h40
`define TWM_ST_R_NACK 8'h48
`define TWM_ST_D_ACK 8'h50
`define TWM_ST_D_NACK 8'h58
`define TWM_ST_IDLE 8'hF8
`define TWM_DATA_RST 8'hFF
`define TWM_ACK_IDX 4'h8
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define TWM_CLK_PERIOD_NS 100
`define TWM_SCL_PERIOD_NS 800
`define TWM_QUARTER_CYC ((`TWM_SCL_PERIOD_NS / `TWM_CLK_PERIOD_NS) / 4)
`endif

// ===== hw/twm_pkg.sv
// Types shared by the two-wire master modules.
package twm_pkg;
  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} twm_cmd_t;
  typedef enum {ENG_IDLE, ENG_WAIT, ENG_START, ENG_BIT, ENG_STOP} twm_eng_t;
endpackage : twm_pkg

// ===== hw/twm_bit_if.sv
// Interface between the register side and the bit sequencer.
`timescale 1ns/1ps
interface twm_bit_if;
  twm_pkg::twm_cmd_t cmd;
  logic cmdValid;
  logic nack;
  logic [7:0] txByte;
  logic done;
  logic arbLost;
  logic ackIn;
  logic [7:0] rxByte;
  logic ownBus;
  logic sclH;
  logic sdaH;
  logic busBusy;
  logic sclOe;
  logic sdaOe;
  modport engine (input cmd, cmdValid, nack, txByte, sclH, sdaH, busBusy,
                  output done, arbLost, ackIn, rxByte, ownBus, sclOe, sdaOe);
  modport ctrl (output cmd, cmdValid, nack, txByte, sclH, sdaH, busBusy,
                input done, arbLost, ackIn, rxByte, ownBus, sclOe, sdaOe);
endinterface : twm_bit_if

// ===== hw/twm_bit_engine.sv
// Bit sequencer for START, STOP and byte transfers on the two-wire bus.
`timescale 1ns/1ps
`include "twm_regs.svh"
module twm_bit_engine (
  input wire logic clk,
  input wire logic rstN,
  twm_bit_if.engine bi
);
  twm_pkg::twm_eng_t state;
  twm_pkg::twm_cmd_t cmdReg;
  logic nackReg;
  logic [1:0] phase;
  logic [3:0] cnt;
  logic [3:0] bitIdx;
  logic [7:0] shiftReg;
  logic tick;
  logic hold;
  logic adv;
  logic arbBit;

  function automatic logic drvBit(input twm_pkg::twm_cmd_t c, input logic [3:0] idx,
                                  input logic msb, input logic nk);
    if (idx == `TWM_ACK_IDX)
      drvBit = (c == twm_pkg::CMD_WRITE) ? 1'b1 : nk;
    else
      drvBit = (c == twm_pkg::CMD_WRITE) ? msb : 1'b1;
  endfunction : drvBit

  // A slave stretching the clock keeps the high phase from advancing.
  assign hold = (phase == 2'h1) && !bi.sclH;
  assign tick = (cnt == 4'(`TWM_QUARTER_CYC - 1));
  assign adv = tick && !hold;
  assign arbBit = (cmdReg == twm_pkg::CMD_WRITE) ? (bitIdx != `TWM_ACK_IDX)
                                                 : (bitIdx == `TWM_ACK_IDX);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      cnt <= 4'h0;
    else if (state == twm_pkg::ENG_IDLE || state == twm_pkg::ENG_WAIT || tick)
      cnt <= 4'h0;
    else if (!hold)
      cnt <= cnt + 4'h1;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state <= twm_pkg::ENG_IDLE;
      cmdReg <= twm_pkg::CMD_START;
      nackReg <= 1'b0;
      phase <= 2'h0;
      bitIdx <= 4'h0;
      shiftReg <= 8'h00;
      bi.done <= 1'b0;
      bi.arbLost <= 1'b0;
      bi.ackIn <= 1'b0;
      bi.rxByte <= 8'h00;
      bi.ownBus <= 1'b0;
      bi.sclOe <= 1'b0;
      bi.sdaOe <= 1'b0;
    end
    else
    begin
      bi.done <= 1'b0;
      if (adv)
        phase <= phase + 2'h1;
      case (state)
        twm_pkg::ENG_IDLE:
          if (bi.cmdValid)
          begin
            cmdReg <= bi.cmd;
            nackReg <= bi.nack;
            shiftReg <= bi.txByte;
            bitIdx <= 4'h0;
            phase <= 2'h0;
            bi.arbLost <= 1'b0;
            if (bi.cmd == twm_pkg::CMD_START)
              state <= twm_pkg::ENG_WAIT;
            else if (bi.cmd == twm_pkg::CMD_STOP)
            begin
              state <= twm_pkg::ENG_STOP;
              bi.sdaOe <= 1'b1;
            end
            else
            begin
              state <= twm_pkg::ENG_BIT;
              bi.sdaOe <= !drvBit(bi.cmd, 4'h0, bi.txByte[7], bi.nack);
            end
          end
        twm_pkg::ENG_WAIT:
          if (!bi.busBusy || bi.ownBus)
          begin
            state <= twm_pkg::ENG_START;
            bi.sdaOe <= 1'b0;
          end
        twm_pkg::ENG_START:
          if (adv)
          begin
            if (phase == 2'h0)
              bi.sclOe <= 1'b0;
            else if (phase == 2'h1)
              bi.sdaOe <= 1'b1;
            else if (phase == 2'h2)
              bi.sclOe <= 1'b1;
            else
            begin
              bi.done <= 1'b1;
              bi.ownBus <= 1'b1;
              state <= twm_pkg::ENG_IDLE;
            end
          end
        twm_pkg::ENG_STOP:
          if (adv)
          begin
            if (phase == 2'h0)
              bi.sclOe <= 1'b0;
            else if (phase == 2'h1)
              bi.sdaOe <= 1'b0;
            else
            begin
              bi.done <= 1'b1;
              bi.ownBus <= 1'b0;
              state <= twm_pkg::ENG_IDLE;
            end
          end
        twm_pkg::ENG_BIT:
          if (adv)
          begin
            if (phase == 2'h0)
              bi.sclOe <= 1'b0;
            else if (phase == 2'h1)
            begin
              if (arbBit && !bi.sdaOe && !bi.sdaH)
              begin
                bi.arbLost <= 1'b1;
                bi.done <= 1'b1;
                bi.ownBus <= 1'b0;
                bi.sdaOe <= 1'b0;
                state <= twm_pkg::ENG_IDLE;
              end
              else if (bitIdx != `TWM_ACK_IDX)
                shiftReg <= {shiftReg[6:0], bi.sdaH};
              else
                bi.ackIn <= !bi.sdaH;
            end
            else if (phase == 2'h2)
              bi.sclOe <= 1'b1;
            else if (bitIdx == `TWM_ACK_IDX)
            begin
              bi.done <= 1'b1;
              bi.rxByte <= shiftReg;
              bi.sdaOe <= 1'b0;
              state <= twm_pkg::ENG_IDLE;
            end
            else
            begin
              bitIdx <= bitIdx + 4'h1;
              bi.sdaOe <= !drvBit(cmdReg, bitIdx + 4'h1, shiftReg[7], nackReg);
            end
          end
        default:
          state <= twm_pkg::ENG_IDLE;
      endcase
    end
  end

  AST_HOLD_SCL: assert property (@(posedge clk) disable iff (!rstN)
    (state == twm_pkg::ENG_IDLE && bi.ownBus) |-> bi.sclOe)
    else $error("Owned idle bus left the clock line released.");
  AST_WAIT_FREE: assert property (@(posedge clk) disable iff (!rstN)
    (state == twm_pkg::ENG_WAIT && bi.busBusy && !bi.ownBus) |=> state == twm_pkg::ENG_WAIT)
    else $error("START issued while another master held the bus.");
endmodule : twm_bit_engine

// ===== hw/twm_top.sv
// Two-wire master receiver with APB register access.
//
// What this block does
// - Master mode entered only after START
// - START waits until bus is free
// - After START: flag set, status 08
// - Writing one clears the step flag
// - Read address sent; status 38/40/48
// - Received byte readable while flag high
// - Final byte answered NACK, then STOP/restart
// - Repeated START reports 10, keeps bus
// - From 10 either direction address allowed
// - Arbitration loss reports 38, releases bus
// - Status 40: receive byte, ACK per enable
// - Status 48: restart/stop, stop self-clears
// - Status 50: next byte, ACK per enable
// - Status 58: restart/stop, stop self-clears
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "twm_regs.svh"
module twm_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic irq
);
  // ---------------------------------------------------------------------------
  // Reset and pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstN;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic sdaPrev;
  logic busBusy;

  twm_bit_if bi ();

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstN = rstSync[1];

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sdaPrev <= sdaSync[1];
    end
  end

  // The bus counts as taken from any START seen on the wires to the next STOP.
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      busBusy <= 1'b0;
    else if (sclSync[1] && sdaPrev && !sdaSync[1])
      busBusy <= 1'b1;
    else if (sclSync[1] && !sdaPrev && sdaSync[1])
      busBusy <= 1'b0;
  end

  assign bi.sclH = sclSync[1];
  assign bi.sdaH = sdaSync[1];
  assign bi.busBusy = busBusy;

  twm_bit_engine engine (
    .clk(ref_clk),
    .rstN(rstN),
    .bi(bi.engine)
  );

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic stepFlag;
  logic ackEn;
  logic startReq;
  logic stopReq;
  logic wcol;
  logic ifEn;
  logic intEn;
  logic [7:0] status;
  logic [7:0] dataReg;
  logic [1:0] irqStat;
  logic [1:0] irqMask;
  logic running;
  logic lastOwned;
  logic lastNack;
  twm_pkg::twm_cmd_t lastCmd;
  logic next_go;
  twm_pkg::twm_cmd_t next_cmd;
  logic wrEn;
  logic ctrlWr;
  logic dataWr;
  logic trigger;
  logic stepSet;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `TWM_OFS_CTRL) || (a == `TWM_OFS_STATUS) || (a == `TWM_OFS_DATA) ||
               (a == `TWM_OFS_IRQ_STAT) || (a == `TWM_OFS_IRQ_MASK);
  endfunction : isMapped

  assign wrEn = psel && penable && pwrite;
  assign ctrlWr = wrEn && (paddr == `TWM_OFS_CTRL);
  assign dataWr = wrEn && (paddr == `TWM_OFS_DATA);
  // A step is only taken when the sequencer is idle and the interface enabled.
  assign trigger = ctrlWr && pwdata[`TWM_CTRL_FLAG] && pwdata[`TWM_CTRL_EN] && !running;
  assign stepSet = bi.done && (lastCmd != twm_pkg::CMD_STOP);

  // ---------------------------------------------------------------------------
  // Next bus step
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_go = 1'b0;
    next_cmd = twm_pkg::CMD_START;
    if (trigger)
    begin
      if (pwdata[`TWM_CTRL_STO] && bi.ownBus)
      begin
        next_go = 1'b1;
        next_cmd = twm_pkg::CMD_STOP;
      end
      else if (pwdata[`TWM_CTRL_STA])
      begin
        next_go = 1'b1;
        next_cmd = twm_pkg::CMD_START;
      end
      else if (bi.ownBus && (status == `TWM_ST_START || status == `TWM_ST_RSTART))
      begin
        next_go = 1'b1;
        next_cmd = twm_pkg::CMD_WRITE;
      end
      else if (bi.ownBus && (status == `TWM_ST_R_ACK || status == `TWM_ST_D_ACK))
      begin
        next_go = 1'b1;
        next_cmd = twm_pkg::CMD_READ;
      end
    end
    else if (bi.done && lastCmd == twm_pkg::CMD_STOP && startReq)
    begin
      next_go = 1'b1;
      next_cmd = twm_pkg::CMD_START;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      bi.cmdValid <= 1'b0;
      bi.cmd <= twm_pkg::CMD_START;
      bi.nack <= 1'b0;
      bi.txByte <= 8'h00;
      lastCmd <= twm_pkg::CMD_START;
      lastOwned <= 1'b0;
      lastNack <= 1'b0;
    end
    else
    begin
      bi.cmdValid <= next_go;
      if (next_go)
      begin
        bi.cmd <= next_cmd;
        bi.nack <= !pwdata[`TWM_CTRL_ACK];
        bi.txByte <= dataReg;
        lastCmd <= next_cmd;
        lastOwned <= bi.ownBus;
        lastNack <= !pwdata[`TWM_CTRL_ACK];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      running <= 1'b0;
    else if (next_go)
      running <= 1'b1;
    else if (bi.done)
      running <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Status code
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      status <= `TWM_ST_IDLE;
    else if (bi.done)
    begin
      case (lastCmd)
        twm_pkg::CMD_START:
          status <= lastOwned ? `TWM_ST_RSTART : `TWM_ST_START;
        twm_pkg::CMD_STOP:
          status <= `TWM_ST_IDLE;
        twm_pkg::CMD_WRITE:
          if (bi.arbLost)
            status <= `TWM_ST_ARB;
          else if (bi.txByte[`TWM_RW_BIT])
            status <= bi.ackIn ? `TWM_ST_R_ACK : `TWM_ST_R_NACK;
          else
            status <= bi.ackIn ? `TWM_ST_W_ACK : `TWM_ST_W_NACK;
        twm_pkg::CMD_READ:
          if (bi.arbLost)
            status <= `TWM_ST_ARB;
          else
            status <= lastNack ? `TWM_ST_D_NACK : `TWM_ST_D_ACK;
        default:
          status <= `TWM_ST_IDLE;
      endcase
    end
    else if (trigger && !next_go && status == `TWM_ST_ARB)
      status <= `TWM_ST_IDLE;
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // The hardware set of the flag wins over a clearing write in the same cycle.
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      stepFlag <= 1'b0;
    else if (stepSet)
      stepFlag <= 1'b1;
    else if (ctrlWr && pwdata[`TWM_CTRL_FLAG])
      stepFlag <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ackEn <= 1'b0;
      startReq <= 1'b0;
      ifEn <= 1'b0;
      intEn <= 1'b0;
    end
    else if (ctrlWr)
    begin
      ackEn <= pwdata[`TWM_CTRL_ACK];
      startReq <= pwdata[`TWM_CTRL_STA];
      ifEn <= pwdata[`TWM_CTRL_EN];
      intEn <= pwdata[`TWM_CTRL_IE];
    end
  end

  // A stop request only means something while the bus is ours.
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      stopReq <= 1'b0;
    else if (ctrlWr)
      stopReq <= pwdata[`TWM_CTRL_STO] && bi.ownBus;
    else if (bi.done && lastCmd == twm_pkg::CMD_STOP)
      stopReq <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Data register and write collision
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      dataReg <= `TWM_DATA_RST;
    else if (bi.done && lastCmd == twm_pkg::CMD_READ && !bi.arbLost)
      dataReg <= bi.rxByte;
    else if (dataWr && stepFlag)
      dataReg <= pwdata[7:0];
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      wcol <= 1'b0;
    else if (dataWr)
      wcol <= !stepFlag;
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      irqStat <= 2'h0;
    else
      irqStat <= (irqStat & ~((wrEn && paddr == `TWM_OFS_IRQ_STAT) ? pwdata[1:0] : 2'h0))
                 | {bi.done && bi.arbLost, stepSet};
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      irqMask <= 2'h0;
    else if (wrEn && paddr == `TWM_OFS_IRQ_MASK)
      irqMask <= pwdata[1:0];
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      irq <= 1'b0;
    else
      irq <= (|(irqStat & irqMask)) || (stepFlag && intEn);
  end

  // ---------------------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `TWM_OFS_CTRL:
          prdata <= {24'h00_0000, stepFlag, ackEn, startReq, stopReq, wcol, ifEn, 1'b0, intEn};
        `TWM_OFS_STATUS:
          prdata <= {24'h00_0000, status};
        `TWM_OFS_DATA:
          prdata <= {24'h00_0000, dataReg};
        `TWM_OFS_IRQ_STAT:
          prdata <= {30'h0, irqStat};
        `TWM_OFS_IRQ_MASK:
          prdata <= {30'h0, irqMask};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);

  // Disabling the interface lets go of both wires at once.
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = bi.sclOe && ifEn;
  assign sdaOe = bi.sdaOe && ifEn;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  AST_MODE_AFTER_START: assert property (
    (bi.cmdValid && bi.cmd == twm_pkg::CMD_WRITE) |-> bi.ownBus)
    else $error("Address sent without a preceding START.");
  AST_START_CODE: assert property (
    (bi.done && lastCmd == twm_pkg::CMD_START && !lastOwned)
      |=> (status == `TWM_ST_START && stepFlag))
    else $error("START did not report 08 with the flag set.");
  AST_FLAG_CLEAR: assert property (
    (ctrlWr && pwdata[`TWM_CTRL_FLAG] && !stepSet) |=> !stepFlag)
    else $error("Step flag not cleared by writing one.");
  AST_ADDR_CODE: assert property (
    (bi.done && lastCmd == twm_pkg::CMD_WRITE && bi.txByte[`TWM_RW_BIT])
      |=> (status == `TWM_ST_ARB || status == `TWM_ST_R_ACK || status == `TWM_ST_R_NACK))
    else $error("Read address gave an unexpected status.");
  AST_RX_DATA: assert property (
    (bi.done && lastCmd == twm_pkg::CMD_READ && !bi.arbLost)
      |=> (dataReg == $past(bi.rxByte) && stepFlag))
    else $error("Received byte not presented in the data register.");
  AST_NACK_LAST: assert property (
    (bi.done && lastCmd == twm_pkg::CMD_READ && !bi.arbLost && lastNack)
      |=> status == `TWM_ST_D_NACK)
    else $error("NACKed byte did not report 58.");
  AST_RSTART_CODE: assert property (
    (bi.done && lastCmd == twm_pkg::CMD_START && lastOwned) |=> status == `TWM_ST_RSTART)
    else $error("Repeated START did not report 10.");
  AST_ARB_LOST: assert property (
    (bi.done && bi.arbLost) |=> (status == `TWM_ST_ARB && !bi.ownBus && !sclOe))
    else $error("Arbitration loss not reported or bus not released.");
  AST_ACK_DATA: assert property (
    (bi.done && lastCmd == twm_pkg::CMD_READ && !bi.arbLost && !lastNack)
      |=> status == `TWM_ST_D_ACK)
    else $error("ACKed byte did not report 50.");
  AST_STOP_CLEARS: assert property (
    (bi.done && lastCmd == twm_pkg::CMD_STOP && !ctrlWr) |=> (!stopReq && !stepFlag))
    else $error("Stop request not self-cleared after STOP.");

  COV_START: cover property (bi.done && lastCmd == twm_pkg::CMD_START);
  COV_READ_BYTE: cover property (bi.done && lastCmd == twm_pkg::CMD_READ && !bi.arbLost);
  COV_ARB: cover property (bi.done && bi.arbLost);
  COV_STOP_START: cover property (bi.done && lastCmd == twm_pkg::CMD_STOP && next_go);
endmodule : twm_top

// ===== testbench/twm_slave_model.sv
// Slave transmitter model on the far side of the two-wire bus.
`timescale 1ns/1ps
module twm_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2A,
  parameter logic [7:0] FIRST_BYTE = 8'hC3
) (
  input wire logic scl,
  input wire logic sda,
  output logic sdaOe
);
  logic [7:0] shiftIn;
  logic [7:0] outByte;
  logic masterNack;
  int i;
  initial sdaOe = 1'b0;
  // Only a START wakes the model, so a STOP or a NACK leaves it idle.
  always
  begin
    @(negedge sda iff scl === 1'b1);
    for (i = 0; i < 8; i++)
    begin
      @(posedge scl);
      shiftIn = {shiftIn[6:0], sda};
    end
    @(negedge scl);
    if (shiftIn == {OWN_ADDR, 1'b1})
    begin
      sdaOe = 1'b1;
      @(negedge scl);
      outByte = FIRST_BYTE;
      masterNack = 1'b0;
      while (!masterNack)
      begin
        for (i = 7; i >= 0; i--)
        begin
          sdaOe = ~outByte[i];
          @(negedge scl);
        end
        sdaOe = 1'b0;
        @(posedge scl);
        masterNack = sda;
        @(negedge scl);
        outByte = outByte + 8'h01;
      end
    end
  end
endmodule : twm_slave_model

// ===== testbench/test_two_wire_master_receiver.sv
// Self-checking bench for the two-wire master receiver.
`timescale 1ns/1ps
`include "twm_regs.svh"
module test_two_wire_master_receiver;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, irq, slvOe, err;
  // Stands in for a rival master that pulls the data line to win arbitration.
  logic rivalOe = 1'b0;
  int failures = 0;
  int nChecks = 0;
  // Both lines have pull-ups, so a wire is low only while some party pulls it.
  wire scl = ~sclOe;
  wire sda = ~(sdaOe | slvOe | rivalOe);
  always #50 ref_clk = ~ref_clk;
  twm_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
  twm_slave_model #(.OWN_ADDR(7'h2A), .FIRST_BYTE(8'hC3)) slave (.scl(scl), .sda(sda),
    .sdaOe(slvOe));
  task complete_run;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      complete_run();
    end
  endtask : apb
  task waitFor(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do
    begin
      apb(a, 1'b0, 32'h0);
      k++;
    end
    while ((rd & m) !== v && k < 200);
    if (k >= 200)
    begin
      failures++;
      complete_run();
    end
  endtask : waitFor
  task step(input logic [31:0] c, input logic [7:0] st);
    apb(`TWM_OFS_CTRL, 1'b1, c);
    waitFor(`TWM_OFS_CTRL, 32'h80, 32'h80);
    apb(`TWM_OFS_STATUS, 1'b0, 32'h0);
    chk("status", rd, {24'h0, st});
  endtask : step
  task stopBus;
    apb(`TWM_OFS_CTRL, 1'b1, 32'h94);
    waitFor(`TWM_OFS_STATUS, 32'hFF, 32'hF8);
    apb(`TWM_OFS_CTRL, 1'b0, 32'h0);
    chk("stop request cleared", rd & 32'h90, 32'h0);
    chk("bus released", {sclOe, sdaOe}, 32'h0);
  endtask : stopBus
  task resetValues;
    apb(`TWM_OFS_STATUS, 1'b0, 32'h0);
    chk("idle status", rd, 32'hF8);
    apb(`TWM_OFS_DATA, 1'b0, 32'h0);
    chk("data reset", rd, 32'hFF);
    apb(8'h14, 1'b0, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    chk("idle pins", {irq, sclOe, sdaOe, sclOut, sdaOut}, 32'h0);
  endtask : resetValues
  task readTwo;
    step(32'hA4, `TWM_ST_START);
    chk("clock held", sclOe, 1'b1);
    chk("masked irq", irq, 1'b0);
    apb(`TWM_OFS_IRQ_MASK, 1'b1, 32'h1);
    apb(`TWM_OFS_IRQ_MASK, 1'b0, 32'h0);
    chk("irq raised", {rd[30:0], irq}, 32'h3);
    apb(`TWM_OFS_IRQ_STAT, 1'b1, 32'h1);
    apb(`TWM_OFS_IRQ_STAT, 1'b0, 32'h0);
    chk("irq cleared", {rd[30:0], irq}, 32'h0);
    apb(`TWM_OFS_DATA, 1'b1, {24'h0, 7'h2A, 1'b1});
    step(32'h84, `TWM_ST_R_ACK);
    step(32'hC4, `TWM_ST_D_ACK);
    apb(`TWM_OFS_DATA, 1'b0, 32'h0);
    chk("first byte", rd, 32'hC3);
    step(32'h84, `TWM_ST_D_NACK);
    apb(`TWM_OFS_DATA, 1'b0, 32'h0);
    chk("last byte", rd, 32'hC4);
    stopBus();
    apb(`TWM_OFS_DATA, 1'b1, 32'h55);
    apb(`TWM_OFS_CTRL, 1'b0, 32'h0);
    chk("collision", rd[3], 1'b1);
  endtask : readTwo
  task restartPaths;
    step(32'hA4, `TWM_ST_START);
    apb(`TWM_OFS_DATA, 1'b1, {24'h0, 7'h11, 1'b1});
    step(32'h84, `TWM_ST_R_NACK);
    step(32'hA4, `TWM_ST_RSTART);
    apb(`TWM_OFS_DATA, 1'b1, {24'h0, 7'h2A, 1'b0});
    step(32'h84, `TWM_ST_W_NACK);
    step(32'hA4, `TWM_ST_RSTART);
    apb(`TWM_OFS_DATA, 1'b1, {24'h0, 7'h2A, 1'b1});
    step(32'h84, `TWM_ST_R_ACK);
    step(32'h84, `TWM_ST_D_NACK);
    step(32'hB4, `TWM_ST_START);
    stopBus();
  endtask : restartPaths
  task arbLoss;
    step(32'hA4, `TWM_ST_START);
    apb(`TWM_OFS_DATA, 1'b1, 32'hFF);
    rivalOe <= 1'b1;
    step(32'h84, `TWM_ST_ARB);
    rivalOe <= 1'b0;
    apb(`TWM_OFS_IRQ_STAT, 1'b0, 32'h0);
    chk("arb irq", {rd[29:0], sclOe, sdaOe}, 32'hC);
    apb(`TWM_OFS_IRQ_STAT, 1'b1, 32'h3);
    apb(`TWM_OFS_CTRL, 1'b1, 32'h05);
    apb(`TWM_OFS_CTRL, 1'b0, 32'h0);
    chk("flag irq", {rd[7], rd[0], irq}, 32'h7);
    apb(`TWM_OFS_CTRL, 1'b1, 32'h84);
    apb(`TWM_OFS_STATUS, 1'b0, 32'h0);
    chk("arb release", {rd[30:0], irq}, 32'h1F0);
  endtask : arbLoss
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    resetValues();
    readTwo();
    restartPaths();
    arbLoss();
    complete_run();
  end
endmodule : test_two_wire_master_receiver
